// ===== vap_core.sv
// pulse-frequency output and per-phase energy accumulation,
// with a small register file
// assumes all power, rms and zero-crossing inputs come from logic on
// clock_i; register port gives read data in the cycle after rd_i
//
// Behaviour
// R1: equal numerator and denominator give 64-clock output pulses.
// R2: den above num: width is period times rounded half den.
// R3: period above 180 ms forces a 90 ms pulse width.
// R4: compute mode bits 2..4 pick phases for the total.
// R5: signed reactive sum; bit 6 negates phases with negative active power.
// R6: software should set active absolute mode with sign following.
// R7: one output pulse per den/num converter pulses.
// R8: waveform mode bit 7 selects apparent power; resets to reactive.
// R9: line-cycle bit latches reactive energy after the zero-cross count.
// R10: software keeps clear-on-read off in line-cycle mode.
// R11: apparent power is vrms times irms, unsigned, low-pass filtered.
// R12: signed gain scales averaged apparent power by 1 + gain/4096.
// R13: gain 0x800 halves, 0x7ff raises by half.
// R14: apparent path carries no offset correction of its own.
// R15: unsigned 41-bit accumulator; register shows upper 16 bits.
// R16: 8-bit divider before accumulation; 0 and 1 mean no division.
// R17: apparent accumulator wraps to zero on overflow and keeps counting.
// R18: mask bit 2 interrupts when any apparent energy msb changes.
// R19: clear-on-read zeroes apparent energy after its read.
// R20: accumulators add a sample every four clocks.
// R21: masked set flag drives the interrupt low.
// R22: line-cycle registers hold the last result until the next completes.
// R23: width rules apply to reactive and apparent sources.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module vap_core
    import vap_pkg::*;
#(
    parameter int LONG_PERIOD_CYC = LONG_PERIOD_MS * CYC_PER_MS,
    parameter int LONG_WIDTH_CYC = LONG_WIDTH_MS * CYC_PER_MS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // per-phase rms values
    input wire logic [RMS_W-1:0] vrms_a_i,
    input wire logic [RMS_W-1:0] vrms_b_i,
    input wire logic [RMS_W-1:0] vrms_c_i,
    input wire logic [RMS_W-1:0] irms_a_i,
    input wire logic [RMS_W-1:0] irms_b_i,
    input wire logic [RMS_W-1:0] irms_c_i,
    // per-phase averaged signed active and reactive power
    input wire logic signed [PQ_W-1:0] active_a_i,
    input wire logic signed [PQ_W-1:0] active_b_i,
    input wire logic signed [PQ_W-1:0] active_c_i,
    input wire logic signed [PQ_W-1:0] reactive_a_i,
    input wire logic signed [PQ_W-1:0] reactive_b_i,
    input wire logic signed [PQ_W-1:0] reactive_c_i,
    // one-cycle pulse per line zero crossing
    input wire logic zero_cross_i,
    // outputs
    output logic reactive_pulse_out_o,
    output logic irq_n_o
);

    // configuration registers
    logic [7:0] compute_mode_reg_r;
    logic [7:0] waveform_mode_reg_r;
    logic [7:0] line_cycle_mode_reg_r;
    logic [15:0] zero_cross_count_r;
    logic [11:0] pulse_div_numerator_r;
    logic [11:0] pulse_div_denominator_r;
    logic [GAIN_W-1:0] apparent_gain_r [PHASES];
    logic [7:0] apparent_divider_r;
    logic [7:0] irq_mask_r;
    logic apparent_half_full_flag_r;
    logic [DATA_W-1:0] rdata_r;

    // shared datapath signals
    logic [RMS_W-1:0] vrms [PHASES];
    logic [RMS_W-1:0] irms [PHASES];
    logic signed [PQ_W-1:0] act [PHASES];
    logic signed [PQ_W-1:0] rea [PHASES];
    logic signed [PQ_W:0] q_eff [PHASES];
    logic [SCALED_W-1:0] app_scaled [PHASES];
    logic [ACC_W-1:0] va_acc_r [PHASES];
    logic signed [ACC_W-1:0] var_acc_r [PHASES];
    logic [E_REG_W-1:0] var_hold_r [PHASES];
    logic [PHASES-1:0] half_evt;
    logic [PHASES-1:0] va_rd_clr;
    logic [1:0] sample_cnt_r;
    logic sample_en;
    logic [15:0] lc_cnt_r;
    logic lc_done_r;
    logic line_cycle_reactive;
    logic clear_on_read;

    assign vrms = '{vrms_a_i, vrms_b_i, vrms_c_i};
    assign irms = '{irms_a_i, irms_b_i, irms_c_i};
    assign act = '{active_a_i, active_b_i, active_c_i};
    assign rea = '{reactive_a_i, reactive_b_i, reactive_c_i};
    assign line_cycle_reactive = line_cycle_mode_reg_r[LC_REACT_BIT];
    assign clear_on_read = line_cycle_mode_reg_r[LC_CLR_READ_BIT];

    // address match within a phase group
    function automatic logic in_group(input logic [7:0] a,
                                      input logic [7:0] base, input int ph);
        in_group = (a == base + 8'(ph));
    endfunction

    // sample strobe every four clocks
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sample_cnt_r <= 2'h0;
        end else begin
            sample_cnt_r <= sample_cnt_r + 2'h1; // R20
        end
    end
    assign sample_en = (sample_cnt_r == SAMPLE_LAST);

    // register writes
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            compute_mode_reg_r <= MODE_RST;
            waveform_mode_reg_r <= MODE_RST; // R8
            line_cycle_mode_reg_r <= MODE_RST;
            zero_cross_count_r <= ZC_RST;
            pulse_div_numerator_r <= DIV_RST;
            pulse_div_denominator_r <= DIV_RST;
            apparent_divider_r <= MODE_RST;
            irq_mask_r <= MODE_RST;
        end else if (wr_i) begin
            case (addr_i)
                OFS_COMPUTE_MODE: compute_mode_reg_r <= wdata_i[7:0];
                OFS_WAVEFORM_MODE: waveform_mode_reg_r <= wdata_i[7:0];
                OFS_LINE_CYCLE_MODE: line_cycle_mode_reg_r <= wdata_i[7:0];
                OFS_ZERO_CROSS_COUNT: zero_cross_count_r <= wdata_i;
                OFS_PULSE_DIV_NUM: pulse_div_numerator_r <= wdata_i[11:0];
                OFS_PULSE_DIV_DEN: pulse_div_denominator_r <= wdata_i[11:0];
                OFS_APP_DIVIDER: apparent_divider_r <= wdata_i[7:0];
                OFS_IRQ_MASK: irq_mask_r <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    // line-cycle zero-crossing counter
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            lc_cnt_r <= ZC_RST;
            lc_done_r <= 1'b0;
        end else begin
            lc_done_r <= 1'b0;
            if (!line_cycle_reactive) begin
                lc_cnt_r <= zero_cross_count_r;
            end else if (zero_cross_i) begin
                if (lc_cnt_r <= 16'h0001) begin
                    lc_done_r <= 1'b1; // R9
                    lc_cnt_r <= zero_cross_count_r;
                end else begin
                    lc_cnt_r <= lc_cnt_r - 16'h0001;
                end
            end
        end
    end

    // per-phase apparent and reactive paths
    genvar ph;
    generate
        for (ph = 0; ph < PHASES; ph++) begin : g_phase
            logic [APP_W-1:0] app_prod_r;
            logic [APP_W-1:0] app_avg_r;
            logic signed [APP_W:0] app_diff;
            logic [13:0] gain_mult;
            logic [APP_W+13:0] gain_prod;
            logic [SCALED_W-1:0] app_div;
            logic [ACC_W-1:0] va_nxt;

            // unsigned rms product, no offset term
            assign app_diff = $signed({1'b0, app_prod_r})
                - $signed({1'b0, app_avg_r}); // R11 R14
            assign gain_mult = GAIN_ONE
                + {{2{apparent_gain_r[ph][GAIN_W-1]}}, apparent_gain_r[ph]};
            assign gain_prod = app_avg_r * gain_mult; // R12 R13
            assign app_scaled[ph] = gain_prod[GAIN_SHIFT +: SCALED_W];
            // a combinational divide keeps the four-clock sample rate
            assign app_div = (apparent_divider_r <= 8'h01) ? app_scaled[ph]
                : app_scaled[ph] / SCALED_W'(apparent_divider_r); // R16
            assign va_nxt = va_acc_r[ph] + ACC_W'(app_div); // R15 R17
            assign va_rd_clr[ph] = rd_i && clear_on_read
                && in_group(addr_i, OFS_APP_ENERGY_A, ph);
            assign half_evt[ph] = sample_en && !va_rd_clr[ph]
                && (va_nxt[ACC_W-1] != va_acc_r[ph][ACC_W-1]); // R18
            assign q_eff[ph] = (compute_mode_reg_r[CM_SIGN_FOLLOW_BIT]
                && act[ph][PQ_W-1]) ? -(PQ_W+1)'(rea[ph])
                : (PQ_W+1)'(rea[ph]); // R5

            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    app_prod_r <= '0;
                    app_avg_r <= '0;
                end else if (sample_en) begin
                    app_prod_r <= vrms[ph] * irms[ph]; // R11
                    app_avg_r <= app_avg_r
                        + APP_W'(app_diff >>> LPF_SHIFT); // R11
                end
            end

            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    va_acc_r[ph] <= '0;
                end else if (va_rd_clr[ph]) begin
                    va_acc_r[ph] <= '0; // R19
                end else if (sample_en) begin
                    va_acc_r[ph] <= va_nxt; // R20
                end
            end

            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    var_acc_r[ph] <= '0;
                    var_hold_r[ph] <= '0;
                end else if (line_cycle_reactive && lc_done_r) begin
                    var_hold_r[ph] <= var_acc_r[ph][ACC_W-1 -: E_REG_W]; // R9
                    var_acc_r[ph] <= '0; // R22
                end else if (sample_en) begin
                    var_acc_r[ph] <= var_acc_r[ph] + ACC_W'(rea[ph]);
                end
            end
        end
    endgenerate

    // apparent gain registers
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            apparent_gain_r <= '{default: '0};
        end else if (wr_i) begin
            for (int i = 0; i < PHASES; i++) begin
                if (in_group(addr_i, OFS_APP_GAIN_A, i)) begin
                    apparent_gain_r[i] <= wdata_i[GAIN_W-1:0];
                end
            end
        end
    end

    // half-full status: a set in the clearing cycle wins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            apparent_half_full_flag_r <= 1'b0;
        end else if (|half_evt) begin
            apparent_half_full_flag_r <= 1'b1; // R18
        end else if (rd_i && addr_i == OFS_IRQ_STATUS) begin
            apparent_half_full_flag_r <= 1'b0;
        end
    end
    assign irq_n_o = !(apparent_half_full_flag_r
        && irq_mask_r[IRQ_HALF_BIT]); // R21

    // register reads
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (rd_i) begin
                case (addr_i)
                    OFS_COMPUTE_MODE: rdata_r <= {8'h00, compute_mode_reg_r};
                    OFS_WAVEFORM_MODE: rdata_r <= {8'h00, waveform_mode_reg_r};
                    OFS_LINE_CYCLE_MODE:
                        rdata_r <= {8'h00, line_cycle_mode_reg_r};
                    OFS_ZERO_CROSS_COUNT: rdata_r <= zero_cross_count_r;
                    OFS_PULSE_DIV_NUM: rdata_r <= {4'h0, pulse_div_numerator_r};
                    OFS_PULSE_DIV_DEN:
                        rdata_r <= {4'h0, pulse_div_denominator_r};
                    OFS_APP_DIVIDER: rdata_r <= {8'h00, apparent_divider_r};
                    OFS_IRQ_MASK: rdata_r <= {8'h00, irq_mask_r};
                    OFS_IRQ_STATUS: rdata_r <= DATA_W'(
                        {apparent_half_full_flag_r, 2'b00});
                    default: begin
                        for (int i = 0; i < PHASES; i++) begin
                            if (in_group(addr_i, OFS_APP_GAIN_A, i)) begin
                                rdata_r <= {4'h0, apparent_gain_r[i]};
                            end
                            if (in_group(addr_i, OFS_APP_ENERGY_A, i)) begin
                                rdata_r <= va_acc_r[i][ACC_W-1 -: E_REG_W];
                            end
                            if (in_group(addr_i, OFS_REACT_ENERGY_A, i)) begin
                                rdata_r <= line_cycle_reactive ? var_hold_r[i]
                                    : var_acc_r[i][ACC_W-1 -: E_REG_W];
                            end
                        end
                    end
                endcase
            end
        end
    end
    assign rdata_o = rdata_r;

    // converter input
    logic signed [PQ_W+2:0] total_q;
    logic [SCALED_W+1:0] total_s;
    logic [SCALED_W+1:0] dfc_in;
    always_comb begin
        total_q = '0;
        total_s = '0;
        for (int i = 0; i < PHASES; i++) begin
            if (compute_mode_reg_r[CM_SEL_LSB + i]) begin // R4
                total_q = total_q + (PQ_W+3)'(q_eff[i]); // R5
                total_s = total_s + (SCALED_W+2)'(app_scaled[i]);
            end
        end
        if (waveform_mode_reg_r[WM_SRC_APP_BIT]) begin
            dfc_in = total_s; // R8
        end else if (total_q < 0) begin
            dfc_in = (SCALED_W+2)'(-total_q);
        end else begin
            dfc_in = (SCALED_W+2)'(total_q);
        end
    end

    // converter pulse on accumulator carry
    logic [DFC_W:0] dfc_sum;
    logic [DFC_W-1:0] dfc_acc_r;
    logic dfc_pulse;
    assign dfc_sum = {1'b0, dfc_acc_r} + (DFC_W+1)'(dfc_in);
    assign dfc_pulse = sample_en && dfc_sum[DFC_W];
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            dfc_acc_r <= '0;
        end else if (sample_en) begin
            dfc_acc_r <= dfc_sum[DFC_W-1:0];
        end
    end

    // fractional divider
    logic [11:0] num_eff;
    logic [11:0] den_eff;
    logic [12:0] frac_sum;
    logic [12:0] frac_r;
    logic out_evt;
    assign num_eff = (pulse_div_numerator_r == 12'h000) ? 12'h001
        : pulse_div_numerator_r;
    assign den_eff = (pulse_div_denominator_r == 12'h000) ? 12'h001
        : pulse_div_denominator_r;
    assign frac_sum = frac_r + {1'b0, num_eff};
    assign out_evt = dfc_pulse && (frac_sum >= {1'b0, den_eff}); // R7
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            frac_r <= '0;
        end else if (dfc_pulse) begin
            frac_r <= out_evt ? frac_sum - {1'b0, den_eff} : frac_sum; // R7
        end
    end

    // saturating period between output pulses
    logic [CNT_W-1:0] per_cnt_r;
    logic [CNT_W-1:0] period_now;
    logic [CNT_W-1:0] width_nxt;
    logic [11:0] half_den;
    assign period_now = (per_cnt_r == '1) ? per_cnt_r : per_cnt_r + 32'h1;
    assign half_den = (den_eff + 12'h001) >> 1;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            per_cnt_r <= '0;
        end else if (out_evt) begin
            per_cnt_r <= '0;
        end else if (per_cnt_r != '1) begin
            per_cnt_r <= per_cnt_r + 32'h1;
        end
    end

    // same width for either source
    always_comb begin
        if (period_now > CNT_W'(LONG_PERIOD_CYC)) begin
            width_nxt = CNT_W'(LONG_WIDTH_CYC); // R3 R23
        end else if (den_eff > num_eff) begin
            width_nxt = CNT_W'(period_now * half_den); // R2 R23
        end else begin
            width_nxt = PULSE_EQ_CYC; // R1 R23
        end
    end

    // output pulse; a new event restarts the width
    vap_pulse_t pstate_r;
    logic [CNT_W-1:0] wcnt_r;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pstate_r <= PS_IDLE;
            wcnt_r <= '0;
        end else begin
            case (pstate_r)
                PS_IDLE: begin
                    if (out_evt) begin
                        pstate_r <= PS_HIGH;
                        wcnt_r <= width_nxt;
                    end
                end
                PS_HIGH: begin
                    if (out_evt) begin
                        wcnt_r <= width_nxt;
                    end else if (wcnt_r <= 32'h1) begin
                        pstate_r <= PS_IDLE;
                    end else begin
                        wcnt_r <= wcnt_r - 32'h1;
                    end
                end
                default: pstate_r <= PS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reactive_pulse_out_o <= 1'b0;
        end else begin
            reactive_pulse_out_o <= out_evt || (pstate_r == PS_HIGH
                && wcnt_r > 32'h1); // R1
        end
    end

endmodule

// ===== vap_pkg.sv
// constants, register map and state codes of the pulse block
// assumes a 10 MHz single clock and a 16-bit plain register port
package vap_pkg;

    // clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_COMPUTE_MODE = 8'h00;
    localparam logic [7:0] OFS_WAVEFORM_MODE = 8'h01;
    localparam logic [7:0] OFS_LINE_CYCLE_MODE = 8'h02;
    localparam logic [7:0] OFS_ZERO_CROSS_COUNT = 8'h03;
    localparam logic [7:0] OFS_PULSE_DIV_NUM = 8'h04;
    localparam logic [7:0] OFS_PULSE_DIV_DEN = 8'h05;
    localparam logic [7:0] OFS_APP_GAIN_A = 8'h06;
    localparam logic [7:0] OFS_APP_DIVIDER = 8'h09;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0a;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0b;
    localparam logic [7:0] OFS_APP_ENERGY_A = 8'h0c;
    localparam logic [7:0] OFS_REACT_ENERGY_A = 8'h0f;

    // field positions
    localparam int CM_SEL_LSB = 2;
    localparam int CM_ABS_BIT = 5;
    localparam int CM_SIGN_FOLLOW_BIT = 6;
    localparam int WM_SRC_APP_BIT = 7;
    localparam int LC_REACT_BIT = 1;
    localparam int LC_CLR_READ_BIT = 6;
    localparam int IRQ_HALF_BIT = 2;

    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [11:0] DIV_RST = 12'h000;
    localparam logic [15:0] ZC_RST = 16'hffff;

    // datapath
    localparam int PHASES = 3;
    localparam int PQ_W = 24;
    localparam int RMS_W = 16;
    localparam int APP_W = 32;
    localparam int SCALED_W = 33;
    localparam int GAIN_W = 12;
    localparam int GAIN_SHIFT = 12;
    localparam logic [13:0] GAIN_ONE = 14'h1000;
    localparam int LPF_SHIFT = 4;
    localparam int ACC_W = 41;
    localparam int E_REG_W = 16;
    localparam logic [1:0] SAMPLE_LAST = 2'h3;
    localparam int DFC_W = 40;
    localparam int CNT_W = 32;

    // pulse timing
    localparam logic [31:0] PULSE_EQ_CYC = 32'h0000_0040;
    localparam int LONG_PERIOD_MS = 180;
    localparam int LONG_WIDTH_MS = 90;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b01,
        PS_HIGH = 2'b10
    } vap_pulse_t;

endpackage

// ===== vap_core_asserts.sv
// port assertions for vap_core
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module vap_core_asserts
    import vap_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    // outputs
    input wire logic reactive_pulse_out_o,
    input wire logic irq_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    AST_RST_QUIET: assert property (disable iff (1'b0)
        srst_i |=> rdata_o == 16'h0000 && !reactive_pulse_out_o && irq_n_o)
        else $error("reset outputs");
    AST_MODE_W: assert property (rd_i && addr_i <= OFS_LINE_CYCLE_MODE
        |=> rdata_o[15:8] == 8'h00) else $error("mode read too wide");
    AST_GAIN_W: assert property (rd_i && addr_i inside {[8'h04:8'h08]}
        |=> rdata_o[15:12] == 4'h0) else $error("gain read too wide");
    AST_DIV_W: assert property (rd_i && addr_i == OFS_APP_DIVIDER
        |=> rdata_o[15:8] == 8'h00) else $error("divider read too wide");
    AST_STATUS_BITS: assert property (rd_i && addr_i == OFS_IRQ_STATUS
        |=> (rdata_o & 16'hfffb) == 16'h0000) else $error("stray status");
    AST_UNMAPPED: assert property (rd_i && addr_i > 8'h11
        |=> rdata_o == 16'h0000) else $error("unmapped read");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("stray read data");
    AST_IRQ_RELEASE: assert property ($rose(irq_n_o) |-> $past(srst_i)
        || $past(wr_i) || ($past(rd_i) && $past(addr_i) == OFS_IRQ_STATUS))
        else $error("stray irq release");
    AST_PULSE_MIN: assert property ($rose(reactive_pulse_out_o)
        |-> reactive_pulse_out_o[*8]) else $error("pulse too short");

    CV_PULSE: cover property ($rose(reactive_pulse_out_o));
    CV_IRQ: cover property ($fell(irq_n_o));
    CV_STATUS: cover property (rd_i && addr_i == OFS_IRQ_STATUS);
endmodule

bind vap_core vap_core_asserts u_chk (.clock_i(clock_i), .srst_i(srst_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .reactive_pulse_out_o(reactive_pulse_out_o), .irq_n_o(irq_n_o));

// ===== vap_zc_model.sv
// zero-crossing source
// same clock; silent while disabled
`timescale 1ns/1ps
module vap_zc_model #(
    parameter int PERIOD = 1000
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic en_i,
    output logic zero_cross_o
);
    logic [15:0] cnt_r;
    always_ff @(posedge clock_i) begin
        if (srst_i || !en_i) begin
            cnt_r <= 16'h0000;
            zero_cross_o <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0000 : cnt_r + 16'h0001;
            zero_cross_o <= (cnt_r == 16'(PERIOD - 1));
        end
    end
endmodule

// ===== vap_core_tb.sv
// self-checking bench for vap_core
// assumes small long-period parameters
`timescale 1ns/1ps
module vap_core_tb
    import vap_pkg::*;
;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic [15:0] vr = 16'hffff;
    logic [15:0] ir = 16'hffff;
    logic signed [23:0] act = 24'sh000100;
    logic signed [23:0] rea = 24'sh000000;
    logic zc_en = 1'b0;
    logic zc, pout, irq_n;
    int errors = 0;
    int samples_checked = 0;

    vap_core #(.LONG_PERIOD_CYC(2000), .LONG_WIDTH_CYC(100)) DUT (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .vrms_a_i(vr), .vrms_b_i(vr), .vrms_c_i(vr),
        .irms_a_i(ir), .irms_b_i(ir), .irms_c_i(ir),
        .active_a_i(act), .active_b_i(act), .active_c_i(act),
        .reactive_a_i(rea), .reactive_b_i(rea), .reactive_c_i(rea),
        .zero_cross_i(zc), .reactive_pulse_out_o(pout), .irq_n_o(irq_n));
    vap_zc_model #(.PERIOD(1000)) u_zc (.clock_i(clock_i),
        .srst_i(srst_i), .en_i(zc_en), .zero_cross_o(zc));

    initial begin
        forever #50 clock_i = ~clock_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    function automatic logic near(logic [19:0] x, y, t);
        return (x + t >= y) && (y + t >= x);
    endfunction
    task automatic wc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #10 d = rdata_o;
    endtask
    task automatic wt(input logic v, output int n);
        n = 0;
        while (pout !== v) begin
            @(posedge clock_i);
            n++;
            if (n > 60000) begin
                $display("BAD %0t pulse timeout", $time);
                errors++;
                test_done();
            end
        end
    endtask
    // skip two pulses after mode changes
    task automatic meas(output int w, output int p);
        int n;
        repeat (2) begin
            wt(1'b0, n);
            wt(1'b1, n);
        end
        wt(1'b0, w);
        wt(1'b1, n);
        p = w + n;
    endtask

    task automatic t_reset();
        logic [7:0] a[4] = '{OFS_COMPUTE_MODE, OFS_WAVEFORM_MODE,
            OFS_ZERO_CROSS_COUNT, 8'h20};
        logic [15:0] e[4] = '{16'h0000, 16'h0000, ZC_RST, 16'h0000};
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(a[i], d);
            chk(d === e[i], "reset value");
        end
        chk(irq_n === 1'b1 && pout === 1'b0, "idle outputs");
        $display("test reset done");
    endtask
    task automatic t_pulse();
        int w, p1, p8, pa;
        wr(OFS_WAVEFORM_MODE, 16'h0080);
        wr(OFS_COMPUTE_MODE, 16'h007c);
        wr(OFS_PULSE_DIV_NUM, 16'h0001);
        wr(OFS_PULSE_DIV_DEN, 16'h0001);
        wc(600);
        meas(w, p1);
        chk(w == 64 || w == 65, "equal width");
        wr(OFS_PULSE_DIV_DEN, 16'h0008);
        meas(w, p8);
        chk(w == 100 || w == 101, "long width");
        chk(near(p8, 8 * p1, p1 / 2), "divided rate");
        wr(OFS_PULSE_DIV_DEN, 16'h0001);
        wr(OFS_COMPUTE_MODE, 16'h0064);
        meas(w, pa);
        chk(near(pa, 3 * p1, p1 / 4), "phase select");
        wr(OFS_WAVEFORM_MODE, 16'h0000);
        $display("test pulse done");
    endtask
    task automatic t_app();
        logic [15:0] a, b, c, d;
        int dv[3] = '{2, 0, 1};
        int ex[3] = '{2000, 4000, 4000};
        vr <= 16'h4000;
        ir <= 16'h4000;
        wr(OFS_APP_GAIN_A + 8'h01, 16'h0800);
        wr(OFS_APP_GAIN_A + 8'h02, 16'h07ff);
        wr(OFS_LINE_CYCLE_MODE, 16'h0040);
        wc(500);
        rd(OFS_APP_ENERGY_A, a);
        rd(OFS_APP_ENERGY_A + 8'h01, b);
        rd(OFS_APP_ENERGY_A + 8'h02, c);
        wc(2000);
        rd(OFS_APP_ENERGY_A, a);
        rd(OFS_APP_ENERGY_A + 8'h01, b);
        rd(OFS_APP_ENERGY_A + 8'h02, c);
        chk(near(a, 20'd4000, 20'd200), "energy rate");
        chk(near(2 * b, a, a / 32), "half gain");
        chk(near(2 * c, 3 * a, a / 16), "gain scale");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_APP_DIVIDER, 16'(dv[i]));
            rd(OFS_APP_ENERGY_A, a);
            rd(OFS_APP_ENERGY_A, d);
            chk(d <= 16'h0008, "clear on read");
            wc(1998);
            rd(OFS_APP_ENERGY_A, a);
            chk(near(a, 20'(ex[i]), 20'd150), "divider");
        end
        $display("test apparent done");
    endtask
    task automatic t_ovf();
        logic [15:0] c, s;
        vr <= 16'hffff;
        ir <= 16'hffff;
        rd(OFS_APP_ENERGY_A + 8'h02, c);
        wr(OFS_LINE_CYCLE_MODE, 16'h0000);
        wc(1000);
        rd(OFS_APP_ENERGY_A + 8'h02, c);
        chk(c >= 16'h8000, "past half");
        chk(irq_n === 1'b1, "masked");
        wr(OFS_IRQ_MASK, 16'h0004);
        wc(1);
        chk(irq_n === 1'b0, "interrupt low");
        rd(OFS_IRQ_STATUS, s);
        chk(s[2] === 1'b1, "half full flag");
        wc(500);
        rd(OFS_APP_ENERGY_A + 8'h02, c);
        chk(c < 16'h4000, "wrap to zero");
        wr(OFS_IRQ_MASK, 16'h0000);
        $display("test overflow done");
    endtask
    task automatic t_lc();
        logic [15:0] r0, r1, r2;
        rea <= 24'sh7fffff;
        wr(OFS_ZERO_CROSS_COUNT, 16'h0002);
        wr(OFS_LINE_CYCLE_MODE, 16'h0002);
        zc_en <= 1'b1;
        rd(OFS_REACT_ENERGY_A, r0);
        r1 = r0;
        for (int k = 0; k < 100 && r1 === r0; k++) begin
            wc(20);
            rd(OFS_REACT_ENERGY_A, r1);
        end
        rea <= 24'sh3fffff;
        wc(300);
        rd(OFS_REACT_ENERGY_A, r2);
        chk(r2 === r1 && r1 !== r0, "held result");
        for (int k = 0; k < 100 && r2 === r1; k++) begin
            wc(20);
            rd(OFS_REACT_ENERGY_A, r2);
        end
        chk(near(r2, 20'd62, 20'd6), "line total");
        $display("test line cycle done");
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        t_reset();
        t_pulse();
        t_app();
        t_ovf();
        t_lc();
        test_done();
    end
endmodule
